//--- inc/option_loader_pkg.sv
// shared constants and types for the reset-time option loader
package option_loader_pkg;
    // nonvolatile option area geometry
    localparam int OPT_BYTES = 32;
    localparam int OPT_BITS = OPT_BYTES * 8;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;

    // positions of option fields inside the loaded image
    localparam int POS_PULL_UP = 0;
    localparam int POS_PULL_DOWN = 16;
    localparam int POS_CAP_IN = 32;
    localparam int POS_CAP_OUT = 34;
    localparam int POS_HARDLOCK = 36;
    localparam int POS_CLK_OUT_PIN = 37;
    localparam int POS_MON_RESET = 38;
    localparam int PORT_LINES = 16;
    localparam int CAP_W = 2;

    // register byte addresses
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] REG_OPT_LO = 8'h08;
    localparam logic [ADDR_W-1:0] REG_OPT_HI = 8'h0C;
    localparam int CTRL_RELOAD = 0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // loader states, gray along clear -> load -> done
    typedef enum logic [1:0] {
        LD_CLEAR = 2'h0,
        LD_LOAD = 2'h1,
        LD_DONE = 2'h3
    } load_state_t;

    // streamer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_REQ = 2'h1,
        ST_SHIFT = 2'h3
    } stream_state_t;

    // decoded options as applied to the chip
    typedef struct packed {
        logic [PORT_LINES-1:0] pull_up;
        logic [PORT_LINES-1:0] pull_down;
        logic [CAP_W-1:0] cap_in;
        logic [CAP_W-1:0] cap_out;
        logic watchdog_hardlock;
        logic ext_clk_from_output_pin;
        logic monitor_reset_en;
    } options_t;
endpackage : option_loader_pkg

//--- verilog/option_bit_streamer.sv
// fetches the option area byte by byte and hands it on one bit per cycle
`timescale 1ns/1ps
module option_bit_streamer #(
    parameter int NBYTES = option_loader_pkg::OPT_BYTES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic [$clog2(NBYTES)-1:0] nvm_addr,
    output logic nvm_rd,
    input wire logic nvm_ack,
    input wire logic [option_loader_pkg::BYTE_W-1:0] nvm_data,
    output logic bit_valid,
    output logic bit_value,
    output logic last_bit
);
    localparam int AW = $clog2(NBYTES);
    localparam int BW = option_loader_pkg::BYTE_W;

    if (NBYTES < 2 || (NBYTES & (NBYTES - 1)) != 0) begin : g_bad_nbytes
        $error("NBYTES must be a power of two, at least 2");
    end

    option_loader_pkg::stream_state_t state_q, state_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [BW-1:0] byte_q, byte_d;
    logic [$clog2(BW)-1:0] bit_q, bit_d;
    logic rd_q, rd_d;

    // next state; a start restarts from byte zero whatever is under way
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        byte_d = byte_q;
        bit_d = bit_q;
        rd_d = rd_q;
        case (state_q)
            option_loader_pkg::ST_IDLE: begin
                rd_d = 1'b0;
            end
            option_loader_pkg::ST_REQ: begin
                // hold the read until the memory answers
                if (nvm_ack) begin
                    rd_d = 1'b0;
                    byte_d = nvm_data;
                    bit_d = '0;
                    state_d = option_loader_pkg::ST_SHIFT;
                end
            end
            option_loader_pkg::ST_SHIFT: begin
                byte_d = byte_q >> 1;
                bit_d = bit_q + 1'b1;
                if (&bit_q) begin
                    if (&addr_q) begin
                        state_d = option_loader_pkg::ST_IDLE;
                    end else begin
                        addr_d = addr_q + 1'b1;
                        rd_d = 1'b1;
                        state_d = option_loader_pkg::ST_REQ;
                    end
                end
            end
            default: begin
                state_d = option_loader_pkg::ST_IDLE;
                rd_d = 1'b0;
            end
        endcase
        if (start) begin
            addr_d = '0;
            rd_d = 1'b1;
            state_d = option_loader_pkg::ST_REQ;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= option_loader_pkg::ST_IDLE;
            addr_q <= '0;
            byte_q <= '0;
            bit_q <= '0;
            rd_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            byte_q <= byte_d;
            bit_q <= bit_d;
            rd_q <= rd_d;
        end
    end

    // lsb of each byte first; shifting is purely serial (see [RL5])
    assign nvm_addr = addr_q;
    assign nvm_rd = rd_q;
    assign bit_valid = (state_q == option_loader_pkg::ST_SHIFT) && !start;
    assign bit_value = byte_q[0];
    assign last_bit = bit_valid && (&bit_q) && (&addr_q);
endmodule : option_bit_streamer

//--- verilog/reset_option_loader.sv
// reset-time loader of hardware options from the nonvolatile option area
//
// Function
// [RL1] options come only from a separate 32-byte nonvolatile area, not program space.
// [RL2] one loaded bit turns on the watchdog hardlock so software cannot disable it.
// [RL3] one loaded bit takes the external clock from the oscillator output pin.
// [RL4] one loaded bit lets the external clock monitor reset the system; clear, it cannot.
// [RL5] reset launches a serial transfer of the stored bits into the shift register.
// [RL6] every power-on and brown-out reset first clears then fully reloads the register.
// [RL7] during reset all port lines are inputs with output drivers off.
// [RL8] port pull resistors stay off until the download has fully completed.
// [RL9] download-complete rises only after the last bit, and holds the core in reset till then.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module reset_option_loader #(
    parameter int NBYTES = option_loader_pkg::OPT_BYTES
) (
    input wire logic aclk,
    input wire logic aresetn,
    // reset requests from the supply supervisor, plus the external clock failure flag
    input wire logic por_event,
    input wire logic bor_event,
    input wire logic ext_clock_fail,
    // option memory read port
    output logic [$clog2(NBYTES)-1:0] nvm_addr,
    output logic nvm_rd,
    input wire logic nvm_ack,
    input wire logic [option_loader_pkg::BYTE_W-1:0] nvm_data,
    // applied options
    output option_loader_pkg::options_t options,
    output logic port_drive_allow,
    output logic core_reset_n,
    output logic download_done,
    output logic ext_clock_reset,
    // axi4-lite slave
    input wire logic [option_loader_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [option_loader_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int NBITS = NBYTES * option_loader_pkg::BYTE_W;
    localparam int AW = option_loader_pkg::ADDR_W;

    if (NBITS < option_loader_pkg::POS_MON_RESET + 1 || NBITS < 64) begin : g_bad_nbytes
        $error("option area too small for the decoded fields");
    end

    // word-aligned decode, shared by read and write paths
    function automatic logic is_mapped(input logic [AW-1:0] a);
        return (a == option_loader_pkg::REG_STATUS) || (a == option_loader_pkg::REG_CONTROL)
            || (a == option_loader_pkg::REG_OPT_LO) || (a == option_loader_pkg::REG_OPT_HI);
    endfunction : is_mapped

    option_loader_pkg::load_state_t state_q, state_d;
    logic [NBITS-1:0] cfg_q, cfg_d;
    option_loader_pkg::options_t opt_q, opt_d;
    logic drive_q, drive_d;
    logic core_rst_n_q, core_rst_n_d;
    logic done_q, done_d;
    logic mon_rst_q, mon_rst_d;
    logic start;
    logic bit_valid;
    logic bit_value;
    logic last_bit;
    logic soft_reload_q, soft_reload_d;
    logic reload_req;

    // power-on, brown-out or software request all restart the download
    assign reload_req = por_event || bor_event || soft_reload_q;

    // serial source of the option image (see [RL1])
    option_bit_streamer #(
        .NBYTES(NBYTES)
    ) u_streamer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start),
        .nvm_addr(nvm_addr),
        .nvm_rd(nvm_rd),
        .nvm_ack(nvm_ack),
        .nvm_data(nvm_data),
        .bit_valid(bit_valid),
        .bit_value(bit_value),
        .last_bit(last_bit)
    );

    // start fires in the clear state, from the same edge that wipes the register
    assign start = (state_q == option_loader_pkg::LD_CLEAR);

    // loader sequence and option application
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        opt_d = opt_q;
        drive_d = drive_q;
        core_rst_n_d = core_rst_n_q;
        done_d = done_q;
        case (state_q)
            option_loader_pkg::LD_CLEAR: begin
                state_d = option_loader_pkg::LD_LOAD; // see [RL5]
            end
            option_loader_pkg::LD_LOAD: begin
                if (bit_valid) begin
                    cfg_d = {bit_value, cfg_q[NBITS-1:1]}; // see [RL5]
                end
                if (last_bit) begin
                    // options only go live once the final bit is in
                    state_d = option_loader_pkg::LD_DONE;
                    opt_d.pull_up = cfg_d[option_loader_pkg::POS_PULL_UP +: 16]; // see [RL8]
                    opt_d.pull_down = cfg_d[option_loader_pkg::POS_PULL_DOWN +: 16]; // see [RL8]
                    opt_d.cap_in = cfg_d[option_loader_pkg::POS_CAP_IN +: 2];
                    opt_d.cap_out = cfg_d[option_loader_pkg::POS_CAP_OUT +: 2];
                    opt_d.watchdog_hardlock = cfg_d[option_loader_pkg::POS_HARDLOCK]; // see [RL2]
                    opt_d.ext_clk_from_output_pin =
                        cfg_d[option_loader_pkg::POS_CLK_OUT_PIN]; // see [RL3]
                    opt_d.monitor_reset_en = cfg_d[option_loader_pkg::POS_MON_RESET]; // see [RL4]
                    drive_d = 1'b1;
                    core_rst_n_d = 1'b1; // see [RL9]
                    done_d = 1'b1; // see [RL9]
                end
            end
            option_loader_pkg::LD_DONE: begin
                state_d = option_loader_pkg::LD_DONE;
            end
            default: begin
                state_d = option_loader_pkg::LD_CLEAR;
            end
        endcase
        // a new reset request wins over everything: wipe and reload
        if (reload_req) begin
            state_d = option_loader_pkg::LD_CLEAR;
            cfg_d = '0; // see [RL6]
            opt_d = '0; // see [RL8]
            drive_d = 1'b0; // see [RL7]
            core_rst_n_d = 1'b0; // see [RL9]
            done_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= option_loader_pkg::LD_CLEAR;
            cfg_q <= '0; // see [RL6]
            opt_q <= '0;
            drive_q <= 1'b0; // see [RL7]
            core_rst_n_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
            opt_q <= opt_d;
            drive_q <= drive_d;
            core_rst_n_q <= core_rst_n_d;
            done_q <= done_d;
        end
    end

    // monitor reset only with the option set and options live
    always_comb begin
        mon_rst_d = ext_clock_fail && opt_q.monitor_reset_en && done_q; // see [RL4]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mon_rst_q <= 1'b0;
        end else begin
            mon_rst_q <= mon_rst_d;
        end
    end

    // axi4-lite slave state
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic [AW-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic wlane0_q, wlane0_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;

    // address and data taken in either order; answer once both are held
    always_comb begin
        awready_d = awready_q;
        wready_d = wready_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wlane0_d = wlane0_q;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        soft_reload_d = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            awready_d = 1'b0;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            wready_d = 1'b0;
            wdata_d = s_axi_wdata;
            wlane0_d = s_axi_wstrb[0];
        end
        if (!awready_q && !wready_q && !bvalid_q) begin
            bvalid_d = 1'b1;
            bresp_d = is_mapped(awaddr_q) ? option_loader_pkg::RESP_OKAY
                                          : option_loader_pkg::RESP_SLVERR;
            // only the control word has a write effect
            if (awaddr_q == option_loader_pkg::REG_CONTROL && wlane0_q) begin
                soft_reload_d = wdata_q[option_loader_pkg::CTRL_RELOAD];
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
            awready_d = 1'b1;
            wready_d = 1'b1;
        end
        if (s_axi_arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = is_mapped(s_axi_araddr) ? option_loader_pkg::RESP_OKAY
                                              : option_loader_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                option_loader_pkg::REG_STATUS: rdata_d = {28'h0000000, state_q, done_q, drive_q};
                option_loader_pkg::REG_OPT_LO: rdata_d = cfg_q[31:0];
                option_loader_pkg::REG_OPT_HI: rdata_d = cfg_q[63:32];
                default: rdata_d = 32'h00000000;
            endcase
        end
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= option_loader_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h00000000;
            wlane0_q <= 1'b0;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= option_loader_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
            soft_reload_q <= 1'b0;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wlane0_q <= wlane0_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            soft_reload_q <= soft_reload_d;
        end
    end

    // all outputs straight from flops
    assign options = opt_q;
    assign port_drive_allow = drive_q; // see [RL7]
    assign core_reset_n = core_rst_n_q; // see [RL9]
    assign download_done = done_q;
    assign ext_clock_reset = mon_rst_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
endmodule : reset_option_loader

//--- bench/reset_option_loader_asserts.sv
// concurrent checks on the option loader ports
`timescale 1ns/1ps
module reset_option_loader_asserts #(
    parameter int NBYTES = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_event,
    input wire logic bor_event,
    input wire logic ext_clock_fail,
    input wire logic [$clog2(NBYTES)-1:0] nvm_addr,
    input wire logic nvm_rd,
    input wire logic nvm_ack,
    input wire option_loader_pkg::options_t options,
    input wire logic port_drive_allow,
    input wire logic core_reset_n,
    input wire logic download_done,
    input wire logic ext_clock_reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    logic [$clog2(NBYTES)-1:0] taken_q;
    logic [$clog2(NBYTES)-1:0] taken_d;
    int acks_q;
    int acks_d;
    // last byte taken and bytes taken since byte 0
    always_comb begin
        taken_d = taken_q;
        acks_d = acks_q;
        if (nvm_rd && nvm_ack) begin
            taken_d = nvm_addr;
            acks_d = (nvm_addr == '0) ? 1 : acks_q + 1;
        end
    end
    always_ff @(posedge aclk) begin
        taken_q <= taken_d;
        acks_q <= acks_d;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence byte_taken;
        nvm_rd && nvm_ack;
    endsequence
    sequence shift_gap;
        (!nvm_rd) [*7];
    endsequence
    // a power-on or brown-out restart cuts a byte short, so those attempts are dropped
    a_byte_order: assert property (disable iff (!aresetn || por_event || bor_event)
        byte_taken ##0 (nvm_addr != NBYTES - 1) |=> shift_gap ##[1:4]
        (nvm_rd && nvm_addr == taken_q + 1'b1)) else $error("next byte out of order");
    a_done_count: assert property ($rose(download_done) |-> acks_q == NBYTES)
        else $error("done before all bytes");
    a_pulls_held: assert property (!download_done |-> options == '0)
        else $error("options live before done");
    a_ports_input: assert property (!download_done
        |-> !port_drive_allow && !core_reset_n) else $error("ports or core released early");
    a_done_applies: assert property (download_done
        |-> port_drive_allow && core_reset_n) else $error("done without release");
    a_restart_clears: assert property ((por_event || bor_event)
        |=> !download_done ##1 !download_done) else $error("restart did not clear");
    a_monitor_gate: assert property (ext_clock_reset |->
        $past(ext_clock_fail && options.monitor_reset_en && download_done))
        else $error("monitor reset without cause");
    a_monitor_fires: assert property (ext_clock_fail && options.monitor_reset_en
        && download_done |=> ext_clock_reset) else $error("monitor reset missing");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
endmodule : reset_option_loader_asserts

bind reset_option_loader reset_option_loader_asserts #(.NBYTES(NBYTES)) chk_i (.*);

//--- bench/option_nvm_model.sv
// behavioural option memory answering the loader byte reads
`timescale 1ns/1ps
module option_nvm_model #(
    parameter int NBYTES = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [$clog2(NBYTES)-1:0] nvm_addr,
    input wire logic nvm_rd,
    output logic nvm_ack,
    output logic [7:0] nvm_data
);
    logic [7:0] mem [0:NBYTES-1]; // separate option area
    int delay;
    int wait_q;
    initial begin
        delay = 3;
        for (int k = 0; k < NBYTES; k++) begin
            mem[k] = 8'(k * 37) ^ 8'h5A;
        end
        mem[4] = 8'h79;
    end
    // data toggles outside the ack cycle so a stale byte is never mistaken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nvm_ack <= 1'b0;
            nvm_data <= 8'hA5;
            wait_q <= 0;
        end else if (!nvm_ack && nvm_rd && wait_q >= delay) begin
            nvm_ack <= 1'b1;
            nvm_data <= mem[nvm_addr];
        end else begin
            nvm_ack <= 1'b0;
            nvm_data <= ~nvm_data;
            wait_q <= (nvm_rd && !nvm_ack) ? wait_q + 1 : 0;
        end
    end
endmodule : option_nvm_model

//--- bench/reset_option_loader_tb.sv
// self-checking bench for the reset-time option loader
`timescale 1ns/1ps
module reset_option_loader_tb;
    logic aclk, aresetn, por_event, bor_event, ext_clock_fail, nvm_rd, nvm_ack;
    logic [4:0] nvm_addr;
    logic [7:0] nvm_data, s_axi_awaddr, s_axi_araddr;
    option_loader_pkg::options_t options;
    logic port_drive_allow, core_reset_n, download_done, ext_clock_reset;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fails;
    int checked;

    reset_option_loader #(.NBYTES(32)) reset_option_loader_i (.*);
    option_nvm_model #(.NBYTES(32)) nvm_i (.aclk(aclk), .aresetn(aresetn), .nvm_addr(nvm_addr),
        .nvm_rd(nvm_rd), .nvm_ack(nvm_ack), .nvm_data(nvm_data));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic print_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // image bits laid out as the options struct, msb first
    function automatic logic [38:0] exp_opts;
        return {nvm_i.mem[1], nvm_i.mem[0], nvm_i.mem[3], nvm_i.mem[2], nvm_i.mem[4][1:0],
            nvm_i.mem[4][3:2], nvm_i.mem[4][4], nvm_i.mem[4][5], nvm_i.mem[4][6]};
    endfunction : exp_opts

    task automatic wait_done(input logic lvl);
        int n;
        n = 0;
        while (download_done !== lvl && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 3000) begin
            fails++;
            print_verdict();
        end
    endtask : wait_done

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(s_axi_bvalid && !aw && !w) && n < 50);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp, er);
        check(n < 50, 1'b1); // a spent limit is a mismatch
        if (n >= 50) print_verdict();
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ar;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        ar = 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end while (!(s_axi_rvalid && !ar) && n < 50);
        s_axi_rready <= 1'b0;
        check({s_axi_rresp, s_axi_rdata}, {er, ed});
        check(n < 50, 1'b1); // a spent limit is a mismatch
        if (n >= 50) print_verdict();
    endtask : axi_read

    // load in flight: ports inputs, pulls off, core held; then options applied
    task automatic t_boot;
        repeat (5) @(posedge aclk);
        check({port_drive_allow, core_reset_n, download_done}, 3'h0);
        check(options, 64'h0);
        wait_done(1'b1);
        check(options, exp_opts());
        check({port_drive_allow, core_reset_n}, 2'h3);
        axi_read(option_loader_pkg::REG_STATUS, 32'h0000000F, option_loader_pkg::RESP_OKAY);
    endtask : t_boot

    task automatic t_monitor(input logic en);
        @(posedge aclk);
        ext_clock_fail <= 1'b1;
        repeat (2) @(posedge aclk);
        check(ext_clock_reset, en);
        ext_clock_fail <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : t_monitor

    // power-on restart, then a brown-out in mid-load with a changed image
    task automatic t_restart;
        nvm_i.mem[4] = 8'h12;
        nvm_i.mem[0] = 8'hC3;
        @(posedge aclk);
        por_event <= 1'b1;
        @(posedge aclk);
        por_event <= 1'b0;
        @(posedge aclk);
        check({download_done, port_drive_allow}, 2'h0);
        check(options, 64'h0);
        repeat (100) @(posedge aclk);
        nvm_i.mem[0] = 8'h3C; // byte 0 already fetched: only a full restart sees this
        bor_event <= 1'b1;
        @(posedge aclk);
        bor_event <= 1'b0;
        @(posedge aclk);
        check(download_done, 1'b0);
        wait_done(1'b1);
        check(options, exp_opts());
        t_monitor(1'b0);
    endtask : t_restart

    // software reload with a prompt memory
    task automatic t_soft;
        nvm_i.delay = 0;
        nvm_i.mem[4] = 8'h79;
        axi_write(option_loader_pkg::REG_CONTROL, 32'h00000001, option_loader_pkg::RESP_OKAY);
        wait_done(1'b0);
        wait_done(1'b1);
        check(options, exp_opts());
        t_monitor(1'b1);
    endtask : t_soft

    task automatic t_regs;
        axi_read(option_loader_pkg::REG_OPT_LO, {nvm_i.mem[3], nvm_i.mem[2], nvm_i.mem[1],
            nvm_i.mem[0]}, option_loader_pkg::RESP_OKAY);
        axi_read(option_loader_pkg::REG_OPT_HI, {nvm_i.mem[7], nvm_i.mem[6], nvm_i.mem[5],
            nvm_i.mem[4]}, option_loader_pkg::RESP_OKAY);
        axi_read(option_loader_pkg::REG_CONTROL, 32'h0, option_loader_pkg::RESP_OKAY);
        axi_read(8'h10, 32'h0, option_loader_pkg::RESP_SLVERR);
        axi_write(8'h10, 32'h00000001, option_loader_pkg::RESP_SLVERR);
        axi_write(option_loader_pkg::REG_STATUS, 32'h0, option_loader_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hE; // reload lane off: no reload may start
        axi_write(option_loader_pkg::REG_CONTROL, 32'h00000001, option_loader_pkg::RESP_OKAY);
        axi_read(option_loader_pkg::REG_STATUS, 32'h0000000F, option_loader_pkg::RESP_OKAY);
    endtask : t_regs

    // every input set at time zero, reset held 20 cycles
    initial begin
        fails = 0;
        checked = 0;
        {aresetn, por_event, bor_event, ext_clock_fail} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_boot();
        t_monitor(1'b1);
        t_restart();
        t_soft();
        t_regs();
        print_verdict();
    end
endmodule : reset_option_loader_tb
